// [rtl/ipa_defs.vh]
/*
 * Constants for the interrupt priority arbiter: register offsets,
 * field positions, reset values and source codes.
 * Assumes an 8-bit byte address on the register bus.
 */
`ifndef IPA_DEFS_VH
`define IPA_DEFS_VH

`define IPA_OFF_INFO 8'h00
`define IPA_OFF_FLAGS 8'h04
`define IPA_OFF_USP 8'h08
`define IPA_OFF_ISP 8'h0c
`define IPA_OFF_FIXED 8'h10
`define IPA_OFF_CTRL 8'h40

`define IPA_CTRL_PEND 3
`define IPA_FLG_I 0
`define IPA_FLG_D 1
`define IPA_FLG_U 2
`define IPA_FLG_IPL 4
`define IPA_FLG_BLOCK 8
`define IPA_INFO_NUM 8

`define IPA_IPL_RST 3'h0
`define IPA_IPL_TOP 3'h7
`define IPA_SP_RST 16'h0000

// interrupt numbers of the fixed sources are arbitrary
`define IPA_NUM_NMI 6'h3f
`define IPA_NUM_DBC 6'h3e
`define IPA_NUM_WDT 6'h3d
`define IPA_NUM_STEP 6'h3c
`define IPA_NUM_MATCH 6'h3b
`define IPA_PER_BASE 6'h08
`define IPA_SW_UKEEP 6'h20

`define IPA_K_SW 3'h0
`define IPA_K_NMI 3'h1
`define IPA_K_DBC 3'h2
`define IPA_K_WDT 3'h3
`define IPA_K_PER 3'h4
`define IPA_K_STEP 3'h5
`define IPA_K_MATCH 3'h6

`define IPA_RESP_OK 2'b00
`define IPA_RESP_ERR 2'b10

`endif

// [rtl/ipa_sync.v]
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input may change at any time relative to aclk.
 */
`timescale 1ns/1ps
module ipa_sync #(
    parameter [0:0] INIT = 1'b1
) (
    input wire aclk,
    input wire aresetn,
    input wire d,
    output reg q
);
    reg meta_reg;

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_reg <= INIT;
            q <= INIT;
        end
        else
        begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// [rtl/ipa_pick.v]
/*
 * Combinational pick of the highest-level pending peripheral request.
 * Level 0 means the source is disabled. Equal levels go to the
 * lowest index, which is the fixed hardware ranking among peripherals.
 * Assumes pending bits and levels come from flops on the same clock.
 */
`timescale 1ns/1ps
module ipa_pick #(
    parameter N = 8,
    parameter IW = 3
) (
    input wire [N-1:0] pend,
    input wire [3*N-1:0] lvl,
    output reg found,
    output reg [IW-1:0] idx,
    output reg [2:0] level
);
    integer i;

    always @*
    begin
        found = 1'b0;
        idx = {IW{1'b0}};
        level = 3'h0;
        // walk downward with >= so the lowest index wins a tie
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (pend[i] && lvl[3*i +: 3] != 3'h0 && lvl[3*i +: 3] >= level)
            begin
                found = 1'b1;
                idx = i[IW-1:0];
                level = lvl[3*i +: 3];
            end
        end
    end
endmodule

// [rtl/ipa_arbiter.v]
/*
 * Interrupt acceptance and priority arbiter of a 16-bit CPU.
 * Holds per-source control (level, pending), the flag bits, the
 * priority level and both stack pointers, reached over AXI4-Lite.
 * Assumes the core pulses instr_done at each instruction boundary,
 * with sw_int in the same cycle when that instruction is a software
 * interrupt, and pulses return_from_interrupt with the restored flags and level.
 */
`timescale 1ns/1ps
`include "ipa_defs.vh"
module ipa_arbiter #(
    parameter N = 8,
    parameter IW = 3
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire [N-1:0] periph_req,
    input wire nmi_n,
    input wire dbc_req,
    input wire wdt_req,
    input wire step_req,
    input wire match_req,
    input wire instr_done,
    input wire sw_int,
    input wire [5:0] sw_num,
    input wire return_from_interrupt,
    input wire [2:0] return_from_interrupt_flags,
    input wire [2:0] return_from_interrupt_ipl,
    output wire int_take,
    output reg [5:0] int_num,
    output reg [2:0] int_level,
    output wire flag_i,
    output wire flag_d,
    output wire flag_u,
    output wire [2:0] proc_ipl,
    output wire [15:0] user_stack_pointer,
    output wire [15:0] interrupt_stack_pointer
);
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_INFO = 3'b010;
    localparam [2:0] S_ENTRY = 3'b100;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer b;
        begin
            for (b = 0; b < 4; b = b + 1)
                merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
        end
    endfunction

    function ctrl_hit;
        input [7:0] a;
        begin
            ctrl_hit = (a[7:6] == `IPA_OFF_CTRL >> 6) && (a[5:2] < N) && (a[1:0] == 2'b00);
        end
    endfunction

    function mapped;
        input [7:0] a;
        begin
            mapped = ctrl_hit(a) || a == `IPA_OFF_INFO || a == `IPA_OFF_FLAGS ||
                a == `IPA_OFF_USP || a == `IPA_OFF_ISP || a == `IPA_OFF_FIXED;
        end
    endfunction

    reg [2:0] st_reg;
    reg [2:0] st_next;
    reg [N-1:0] pend_reg;
    reg [3*N-1:0] lvl_reg;
    reg nmi_p_reg, dbc_p_reg, wdt_p_reg, step_p_reg, match_p_reg;
    reg nmi_n_d_reg;
    reg flg_i_reg, flg_d_reg, flg_u_reg;
    reg [2:0] ipl_reg;
    reg [15:0] usp_reg, isp_reg;
    reg first_reg;
    reg [2:0] cap_kind_reg;
    reg [IW-1:0] cap_idx_reg;
    reg [5:0] cap_num_next;
    reg [2:0] cap_kind_next;
    reg [2:0] cap_lvl_next;
    reg take_hw;

    wire nmi_n_s;
    wire pk_found;
    wire [IW-1:0] pk_idx;
    wire [2:0] pk_lvl;
    wire nmi_fall;
    wire periph_ok;
    wire boundary;
    wire wr_go;
    wire rd_go;
    wire wr_ctrl;
    wire [3:0] wr_idx;
    wire rd_info;
    wire [31:0] flags_word;
    wire [31:0] flags_new;
    wire [31:0] usp_merged;
    wire [31:0] isp_merged;
    integer i;

    ipa_sync #(.INIT(1'b1)) u_nmi_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(nmi_n),
        .q(nmi_n_s)
    );

    ipa_pick #(.N(N), .IW(IW)) u_pick (
        .pend(pend_reg),
        .lvl(lvl_reg),
        .found(pk_found),
        .idx(pk_idx),
        .level(pk_lvl)
    );

    assign nmi_fall = nmi_n_d_reg & ~nmi_n_s;
    // peripherals need the enable flag and a strictly higher level
    assign periph_ok = pk_found & flg_i_reg & (pk_lvl > ipl_reg);
    assign boundary = st_reg[0] & instr_done;

    // write address and data are taken together, one write at a time
    assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
    assign wr_ctrl = wr_go & ctrl_hit(s_axi_awaddr);
    assign wr_idx = s_axi_awaddr[5:2];
    assign rd_info = rd_go & (s_axi_araddr == `IPA_OFF_INFO);

    assign flags_word = {23'h000000, first_reg, 1'b0, ipl_reg, 1'b0, flg_u_reg,
        flg_d_reg, flg_i_reg};
    assign flags_new = merge(flags_word, s_axi_wdata, s_axi_wstrb);
    assign usp_merged = merge({16'h0000, usp_reg}, s_axi_wdata, s_axi_wstrb);
    assign isp_merged = merge({16'h0000, isp_reg}, s_axi_wdata, s_axi_wstrb);

    assign int_take = st_reg[2];
    assign flag_i = flg_i_reg;
    assign flag_d = flg_d_reg;
    assign flag_u = flg_u_reg;
    assign proc_ipl = ipl_reg;
    assign user_stack_pointer = usp_reg;
    assign interrupt_stack_pointer = isp_reg;

    // one winner per boundary; sw interrupt is not arbitrated
    always @*
    begin
        take_hw = 1'b1;
        cap_kind_next = `IPA_K_SW;
        cap_num_next = sw_num;
        cap_lvl_next = ipl_reg;
        if (sw_int)
            take_hw = 1'b0;
        else if (nmi_p_reg)
        begin
            cap_kind_next = `IPA_K_NMI;
            cap_num_next = `IPA_NUM_NMI;
            cap_lvl_next = `IPA_IPL_TOP;
        end
        else if (dbc_p_reg)
        begin
            cap_kind_next = `IPA_K_DBC;
            cap_num_next = `IPA_NUM_DBC;
        end
        else if (wdt_p_reg)
        begin
            cap_kind_next = `IPA_K_WDT;
            cap_num_next = `IPA_NUM_WDT;
            cap_lvl_next = `IPA_IPL_TOP;
        end
        else if (periph_ok)
        begin
            cap_kind_next = `IPA_K_PER;
            cap_num_next = `IPA_PER_BASE + {{(6-IW){1'b0}}, pk_idx};
            cap_lvl_next = pk_lvl;
        end
        else if (step_p_reg)
        begin
            cap_kind_next = `IPA_K_STEP;
            cap_num_next = `IPA_NUM_STEP;
        end
        else if (match_p_reg)
        begin
            cap_kind_next = `IPA_K_MATCH;
            cap_num_next = `IPA_NUM_MATCH;
        end
        else
            take_hw = 1'b0;
    end

    always @*
    begin
        case (st_reg)
            S_IDLE:
            begin
                if (boundary && sw_int)
                    st_next = S_ENTRY;
                else if (boundary && take_hw && !first_reg)
                    st_next = (cap_kind_next == `IPA_K_PER) ? S_INFO : S_ENTRY;
                else
                    st_next = S_IDLE;
            end
            S_INFO: st_next = S_ENTRY;
            S_ENTRY: st_next = S_IDLE;
            default: st_next = S_IDLE;
        endcase
    end

    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= S_IDLE;
            cap_kind_reg <= `IPA_K_SW;
            cap_idx_reg <= {IW{1'b0}};
            int_num <= 6'h00;
            int_level <= 3'h0;
            first_reg <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
            if (instr_done)
                first_reg <= 1'b0;
            if (st_reg[0] && st_next != S_IDLE)
            begin
                cap_kind_reg <= cap_kind_next;
                cap_idx_reg <= pk_idx;
                int_num <= cap_num_next;
                int_level <= cap_lvl_next;
            end
        end
    end

    // fixed-source pending flags; a new event beats the clear
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            nmi_n_d_reg <= 1'b1;
            nmi_p_reg <= 1'b0;
            dbc_p_reg <= 1'b0;
            wdt_p_reg <= 1'b0;
            step_p_reg <= 1'b0;
            match_p_reg <= 1'b0;
        end
        else
        begin
            nmi_n_d_reg <= nmi_n_s;
            nmi_p_reg <= nmi_fall |
                (nmi_p_reg & ~(int_take & cap_kind_reg == `IPA_K_NMI));
            dbc_p_reg <= dbc_req | (dbc_p_reg & ~(int_take & cap_kind_reg == `IPA_K_DBC));
            wdt_p_reg <= wdt_req | (wdt_p_reg & ~(int_take & cap_kind_reg == `IPA_K_WDT));
            step_p_reg <= step_req |
                (step_p_reg & ~(int_take & cap_kind_reg == `IPA_K_STEP));
            match_p_reg <= match_req |
                (match_p_reg & ~(int_take & cap_kind_reg == `IPA_K_MATCH));
        end
    end

    // peripheral control: refused requests simply keep their bit
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pend_reg <= {N{1'b0}};
            lvl_reg <= {3*N{1'b0}};
        end
        else
        begin
            for (i = 0; i < N; i = i + 1)
            begin
                if (st_reg[1] && cap_idx_reg == i)
                    pend_reg[i] <= 1'b0;
                if (rd_info && pk_found && pk_idx == i)
                    pend_reg[i] <= 1'b0;
                if (wr_ctrl && wr_idx == i && s_axi_wstrb[0])
                begin
                    lvl_reg[3*i +: 3] <= s_axi_wdata[2:0];
                    pend_reg[i] <= s_axi_wdata[`IPA_CTRL_PEND];
                end
                // request beats any clear or rewrite in the same cycle
                if (periph_req[i])
                    pend_reg[i] <= 1'b1;
            end
        end
    end

    // flags, level and stack pointers; any entry wins over return, return wins over bus writes
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            flg_i_reg <= 1'b0;
            flg_d_reg <= 1'b0;
            flg_u_reg <= 1'b0;
            ipl_reg <= `IPA_IPL_RST;
            usp_reg <= `IPA_SP_RST;
            isp_reg <= `IPA_SP_RST;
        end
        else
        begin
            if (wr_go && s_axi_awaddr == `IPA_OFF_USP)
                usp_reg <= usp_merged[15:0];
            if (wr_go && s_axi_awaddr == `IPA_OFF_ISP)
                isp_reg <= isp_merged[15:0];
            if (st_reg[2])
            begin
                flg_i_reg <= 1'b0;
                flg_d_reg <= 1'b0;
                if (!(cap_kind_reg == `IPA_K_SW && int_num >= `IPA_SW_UKEEP))
                    flg_u_reg <= 1'b0;
                if (cap_kind_reg == `IPA_K_PER || cap_kind_reg == `IPA_K_NMI ||
                    cap_kind_reg == `IPA_K_WDT)
                    ipl_reg <= int_level;
            end
            else if (st_reg[0] && return_from_interrupt)
            begin
                flg_i_reg <= return_from_interrupt_flags[`IPA_FLG_I];
                flg_d_reg <= return_from_interrupt_flags[`IPA_FLG_D];
                flg_u_reg <= return_from_interrupt_flags[`IPA_FLG_U];
                ipl_reg <= return_from_interrupt_ipl;
            end
            else if (wr_go && s_axi_awaddr == `IPA_OFF_FLAGS)
            begin
                flg_i_reg <= flags_new[`IPA_FLG_I];
                flg_d_reg <= flags_new[`IPA_FLG_D];
                flg_u_reg <= flags_new[`IPA_FLG_U];
                ipl_reg <= flags_new[`IPA_FLG_IPL +: 3];
            end
        end
    end

    // bus answers one cycle after the handshake
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `IPA_RESP_OK;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `IPA_RESP_OK;
            s_axi_rdata <= 32'h00000000;
        end
        else
        begin
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(s_axi_awaddr) ? `IPA_RESP_OK : `IPA_RESP_ERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (rd_go)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(s_axi_araddr) ? `IPA_RESP_OK : `IPA_RESP_ERR;
                s_axi_rdata <= 32'h00000000;
                if (rd_info && pk_found)
                    s_axi_rdata <= {18'h00000,
                        `IPA_PER_BASE + {{(6-IW){1'b0}}, pk_idx}, 5'h00, pk_lvl};
                else if (s_axi_araddr == `IPA_OFF_FLAGS)
                    s_axi_rdata <= flags_word;
                else if (s_axi_araddr == `IPA_OFF_USP)
                    s_axi_rdata <= {16'h0000, usp_reg};
                else if (s_axi_araddr == `IPA_OFF_ISP)
                    s_axi_rdata <= {16'h0000, isp_reg};
                else if (s_axi_araddr == `IPA_OFF_FIXED)
                    s_axi_rdata <= {27'h0000000, match_p_reg, step_p_reg, wdt_p_reg,
                        dbc_p_reg, nmi_p_reg};
                else if (ctrl_hit(s_axi_araddr))
                    for (i = 0; i < N; i = i + 1)
                        if (s_axi_araddr[5:2] == i)
                            s_axi_rdata <= {28'h0000000, pend_reg[i], lvl_reg[3*i +: 3]};
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule

// [sim/ipa_checker.sv]
/*
 * Concurrent checks on the ports of the interrupt priority arbiter.
 * Assumes software numbers stay outside the peripheral and fixed codes.
 */
`timescale 1ns/1ps
`include "ipa_defs.vh"
module ipa_checker #(
    parameter N = 8
) (
    input wire aclk,
    input wire aresetn,
    input wire instr_done,
    input wire sw_int,
    input wire [5:0] sw_num,
    input wire int_take,
    input wire [5:0] int_num,
    input wire [2:0] int_level,
    input wire flag_i,
    input wire flag_d,
    input wire flag_u,
    input wire [2:0] proc_ipl,
    input wire [15:0] user_stack_pointer,
    input wire [15:0] interrupt_stack_pointer
);
    reg first_reg;
    wire per_take;

    assign per_take = int_take && int_num >= `IPA_PER_BASE && int_num < `IPA_PER_BASE + N;

    // cleared by the first boundary of any kind
    always @(posedge aclk)
    begin
        if (!aresetn)
            first_reg <= 1'b1;
        else if (instr_done)
            first_reg <= 1'b0;
    end

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // no sequence can still be running: conservative, may skip some boundaries
    sequence quiet_s;
        !int_take && !$past(instr_done) && !$past(instr_done, 2);
    endsequence
    sequence sw_hit_s;
        (instr_done && sw_int) ##0 quiet_s;
    endsequence

    entry_flags_a: assert property (int_take |=> !flag_i && !flag_d)
        else $error("enable or debug flag left set after entry");
    top_level_a: assert property ((int_take && (int_num == `IPA_NUM_NMI ||
        int_num == `IPA_NUM_WDT)) |=> proc_ipl == `IPA_IPL_TOP)
        else $error("pin or watchdog entry did not raise level to top");
    per_level_a: assert property (per_take |=> proc_ipl == int_level)
        else $error("level not loaded from accepted peripheral");
    per_delay_a: assert property (per_take |-> $past(instr_done, 2))
        else $error("peripheral entry without the info cycle");
    nest_gate_a: assert property (per_take |->
        $past(flag_i, 2) && int_level > $past(proc_ipl, 2))
        else $error("peripheral accepted without enable or above level");
    sw_take_a: assert property (sw_hit_s |=> int_take && int_num == $past(sw_num))
        else $error("software interrupt not entered");
    sw_ukeep_a: assert property (sw_hit_s ##0 sw_num[5] |=> ##1 flag_u == $past(flag_u, 2))
        else $error("stack select changed for upper software number");
    sw_uclear_a: assert property (sw_hit_s ##0 !sw_num[5] |=> ##1 !flag_u)
        else $error("stack select kept for lower software number");
    first_block_a: assert property (first_reg && instr_done && !sw_int |=> !int_take [*2])
        else $error("interrupt accepted at first instruction");
    reset_vals_a: assert property ($rose(aresetn) |-> user_stack_pointer == `IPA_SP_RST &&
        interrupt_stack_pointer == `IPA_SP_RST && proc_ipl == `IPA_IPL_RST)
        else $error("stack pointers or level not cleared by reset");
endmodule

// [sim/ipa_core_model.sv]
/*
 * Behavioural core and request sources on the arbiter's event side.
 * Assumes the bench calls one task at a time.
 */
`timescale 1ns/1ps
module ipa_core_model #(
    parameter N = 8
) (
    input wire aclk,
    output reg [N-1:0] periph_req,
    output reg nmi_n,
    output reg dbc_req,
    output reg wdt_req,
    output reg step_req,
    output reg match_req,
    output reg instr_done,
    output reg sw_int,
    output reg [5:0] sw_num,
    output reg return_from_interrupt,
    output reg [2:0] return_from_interrupt_flags,
    output reg [2:0] return_from_interrupt_ipl
);
    integer gap_cyc = 0;

    initial
    begin
        periph_req = {N{1'b0}};
        nmi_n = 1'b1;
        {dbc_req, wdt_req, step_req, match_req} = 4'h0;
        {instr_done, sw_int, return_from_interrupt} = 3'h0;
        sw_num = 6'h2a;
        return_from_interrupt_flags = 3'h5;
        return_from_interrupt_ipl = 3'h2;
    end

    // a slow core idles gap_cyc + 1 cycles before each boundary
    task step_op(input sw, input [5:0] num);
    begin
        repeat (gap_cyc + 1) @(posedge aclk);
        instr_done <= 1'b1;
        sw_int <= sw;
        sw_num <= num;
        @(posedge aclk);
        instr_done <= 1'b0;
        sw_int <= 1'b0;
        sw_num <= ~num;
    end
    endtask

    task ret(input [2:0] fl, input [2:0] lv);
    begin
        @(posedge aclk);
        return_from_interrupt <= 1'b1;
        return_from_interrupt_flags <= fl;
        return_from_interrupt_ipl <= lv;
        @(posedge aclk);
        return_from_interrupt <= 1'b0;
        return_from_interrupt_flags <= ~fl;
        return_from_interrupt_ipl <= ~lv;
    end
    endtask

    task fire(input [N-1:0] per, input [3:0] fix);
    begin
        @(posedge aclk);
        periph_req <= per;
        {match_req, step_req, wdt_req, dbc_req} <= fix;
        @(posedge aclk);
        periph_req <= {N{1'b0}};
        {match_req, step_req, wdt_req, dbc_req} <= 4'h0;
    end
    endtask

    task pin(input lvl);
    begin
        @(posedge aclk);
        nmi_n <= lvl;
    end
    endtask
endmodule

// [sim/test_interrupt_priority_arbiter.sv]
/*
 * Self-checking bench for the interrupt priority arbiter.
 * Assumes the core model drives the event side; bus tasks live here.
 */
`timescale 1ns/1ps
`include "ipa_defs.vh"
module test_interrupt_priority_arbiter;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg [3:0] wstrb = 4'hf, strb = 4'hf;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, nmi_n, dbc, wdt, stp, mtc;
    wire idone, swi, rt, take, fi, fd, fu;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] per;
    wire [5:0] swn, inum;
    wire [2:0] rfl, ripl, ilvl, pipl;
    wire [15:0] user_stack_pointer, interrupt_stack_pointer;
    integer n_fail = 0, checks_done = 0, cycles = 0, i;
    reg [31:0] rd_data;
    reg [1:0] rs;

    always #10 aclk = ~aclk;

    ipa_arbiter #(.N(8), .IW(3)) uut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .periph_req(per), .nmi_n(nmi_n), .dbc_req(dbc), .wdt_req(wdt), .step_req(stp),
        .match_req(mtc), .instr_done(idone), .sw_int(swi), .sw_num(swn), .return_from_interrupt(rt),
        .return_from_interrupt_flags(rfl), .return_from_interrupt_ipl(ripl), .int_take(take), .int_num(inum), .int_level(ilvl),
        .flag_i(fi), .flag_d(fd), .flag_u(fu), .proc_ipl(pipl), .user_stack_pointer(user_stack_pointer), .interrupt_stack_pointer(interrupt_stack_pointer));

    ipa_core_model #(.N(8)) core (.aclk(aclk), .periph_req(per), .nmi_n(nmi_n),
        .dbc_req(dbc), .wdt_req(wdt), .step_req(stp), .match_req(mtc), .instr_done(idone),
        .sw_int(swi), .sw_num(swn), .return_from_interrupt(rt), .return_from_interrupt_flags(rfl), .return_from_interrupt_ipl(ripl));

    task check(input [31:0] seen, input [31:0] exp, input string what);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            n_fail = n_fail + 1;
            $display("FAIL %0s expected %h seen %h", what, exp, seen);
        end
    end
    endtask

    task stop_test;
    begin
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask

    // ready and valid are sampled at the falling edge: stable until the next rise
    task wr(input [7:0] a, input [31:0] d);
    begin
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(negedge aclk);
        while (!(awready && wready))
            @(negedge aclk);
        @(posedge aclk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(negedge aclk);
        while (!bvalid)
            @(negedge aclk);
        rs = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    end
    endtask

    task rdx(input [7:0] a);
    begin
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge aclk);
        while (!arready)
            @(negedge aclk);
        @(posedge aclk);
        arvalid <= 1'b0;
        @(negedge aclk);
        while (!rvalid)
            @(negedge aclk);
        rd_data = rdata;
        rs = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    end
    endtask

    task take_chk(input want, input [5:0] num);
        reg seen;
    begin
        seen = 1'b0;
        repeat (5)
        begin
            @(negedge aclk);
            if (take === 1'b1)
                seen = 1'b1;
        end
        check(seen, want, "take");
        if (want)
            check(inum, num, "number");
    end
    endtask

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdx(`IPA_OFF_FLAGS);
        check(rd_data, 32'h1 << `IPA_FLG_BLOCK, "flags");
        rdx(`IPA_OFF_USP);
        check(rd_data, 32'h0, "user sp");
        rdx(8'h20);
        check(rs, `IPA_RESP_ERR, "unmapped");
        wr(`IPA_OFF_ISP, 32'h5678);
        check(rs, `IPA_RESP_OK, "write resp");
        rdx(`IPA_OFF_ISP);
        check(rd_data, 32'h5678, "intr sp");
        wr(`IPA_OFF_USP, 32'h1234);
        strb = 4'h1;
        wr(`IPA_OFF_USP, 32'h56ab);
        strb = 4'hf;
        rdx(`IPA_OFF_USP);
        check(rd_data, 32'h12ab, "user sp lanes");
        core.pin(1'b0);
        core.fire(8'h00, 4'hf);
        core.step_op(1'b0, 6'h00);
        take_chk(1'b0, 6'h00);
        for (i = 0; i < 5; i = i + 1)
        begin
            core.step_op(1'b0, 6'h00);
            take_chk(1'b1, `IPA_NUM_NMI - i[5:0]);
            if (i == 0)
                check(pipl, `IPA_IPL_TOP, "nmi level");
        end
        check(pipl, `IPA_IPL_TOP, "kept level");
        core.pin(1'b1);
        wr(8'h48, 32'h3);
        wr(8'h54, 32'h5);
        wr(8'h58, 32'h5);
        rdx(`IPA_OFF_FIXED);
        wr(`IPA_OFF_FLAGS, 32'h1);
        core.fire(8'h64, 4'h0);
        core.step_op(1'b0, 6'h00);
        take_chk(1'b1, 6'h0d);
        check(ilvl, 32'h5, "int level");
        check(pipl, 32'h5, "proc level");
        check({fd, fi}, 32'h0, "flags");
        rdx(8'h54);
        check(rd_data, 32'h5, "ctrl5");
        wr(`IPA_OFF_FLAGS, 32'h51);
        core.step_op(1'b0, 6'h00);
        take_chk(1'b0, 6'h00);
        rdx(8'h58);
        check(rd_data, 32'hd, "ctrl6");
        core.ret(3'b001, 3'd4);
        core.step_op(1'b0, 6'h00);
        take_chk(1'b1, 6'h0e);
        rdx(`IPA_OFF_INFO);
        check(rd_data, 32'h0a03, "info");
        rdx(8'h48);
        check(rd_data, 32'h3, "ctrl2");
        wr(8'h44, 32'hb);
        wr(8'h44, 32'h3);
        rdx(8'h44);
        check(rd_data, 32'h3, "ctrl1");
        // request and clearing write meet at one edge: the request must survive
        fork
            wr(8'h44, 32'h3);
            core.fire(8'h02, 4'h0);
        join
        rdx(8'h44);
        check(rd_data, 32'hb, "ctrl1 kept");
        core.gap_cyc = 3;
        wr(`IPA_OFF_FLAGS, 32'h4);
        core.step_op(1'b1, 6'h21);
        take_chk(1'b1, 6'h21);
        check(fu, 32'h1, "u kept");
        core.step_op(1'b1, 6'h05);
        take_chk(1'b1, 6'h05);
        check(fu, 32'h0, "u cleared");
        stop_test;
    end

    always @(posedge aclk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            stop_test;
        end
    end
endmodule

bind ipa_arbiter ipa_checker #(.N(N)) chk (.aclk(aclk), .aresetn(aresetn),
    .instr_done(instr_done), .sw_int(sw_int), .sw_num(sw_num), .int_take(int_take),
    .int_num(int_num), .int_level(int_level), .flag_i(flag_i), .flag_d(flag_d),
    .flag_u(flag_u), .proc_ipl(proc_ipl), .user_stack_pointer(user_stack_pointer), .interrupt_stack_pointer(interrupt_stack_pointer));
